/* File: fsp_pkg.sv */
// Shared constants and types of the four-mode serial port.
// Assumes a single 100 MHz system clock and an 8-bit register port.
package fsp_pkg;

  // Register offsets
  localparam logic [7:0] OFS_BUF   = 8'h00;
  localparam logic [7:0] OFS_CTRL  = 8'h04;
  localparam logic [7:0] OFS_PWR   = 8'h08;
  localparam logic [7:0] OFS_T2CON = 8'h0c;
  localparam logic [7:0] OFS_GIVEN = 8'h10;
  localparam logic [7:0] OFS_BCAST = 8'h14;

  // Field positions
  localparam int BIT_DOUBLE = 7;
  localparam int BIT_SRCSEL = 5;

  // Reset values
  localparam logic [7:0] CTRL_RST  = 8'h00;
  localparam logic [7:0] PWR_RST   = 8'h00;
  localparam logic [7:0] T2CON_RST = 8'h00;
  localparam logic [7:0] GIVEN_RST = 8'h00;
  localparam logic [7:0] BCAST_RST = 8'hff;

  // Mode encodings
  localparam logic [1:0] MODE_SYNC  = 2'h0;
  localparam logic [1:0] MODE_TMR10 = 2'h1;
  localparam logic [1:0] MODE_FIX11 = 2'h2;
  localparam logic [1:0] MODE_TMR11 = 2'h3;

  // Mode 0 shift clock half periods in system clocks (divide by 12 / by 2)
  localparam logic [2:0] M0_HALF_SLOW = 3'h6;
  localparam logic [2:0] M0_HALF_FAST = 3'h1;
  localparam logic [3:0] M0_LAST_BIT  = 4'h7;

  // Oversample tick dividers: fixed mode counts system clocks, timer modes count overflows
  localparam logic [1:0] FIX_DIV_LAST     = 2'h3;
  localparam logic [1:0] FIX_DIV_LAST_DBL = 2'h1;
  localparam logic [1:0] TMR_DIV_LAST     = 2'h1;
  localparam logic [1:0] TMR_DIV_LAST_DBL = 2'h0;

  // Bit timing in oversample ticks
  localparam logic [3:0] TICK_LAST = 4'hf;
  localparam logic [3:0] TICK_MID  = 4'h7;

  // Frame lengths after the start bit
  localparam logic [3:0] TX_LEFT_10 = 4'h9;
  localparam logic [3:0] TX_LEFT_11 = 4'ha;
  localparam logic [3:0] RX_LAST_8  = 4'h7;
  localparam logic [3:0] RX_LAST_9  = 4'h8;

  typedef struct packed {
    logic [1:0] mode;
    logic       mp_sel;
    logic       rx_en;
    logic       tx9;
    logic       rx9;
    logic       tx_done;
    logic       rx_done;
  } fsp_ctrl_t;

endpackage : fsp_pkg

/* File: fsp_serial_port.sv */
// Four-mode serial port: mode 0 shifter and mode 1/2/3 asynchronous port.
// Assumes timer overflow pulses come from logic on sys_clk; rxd pin is asynchronous.
//
// Strobed register access and the register addresses were decided locally.
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - Receive buffer separate from receive shifter
// - Buffer write loads transmitter; read returns receiver
// - Any buffer write starts a transmission
// - Mode 0: half duplex, device drives clock
// - Mode 0 clock: sys/12, or sys/2
// - Mode 0 LSB first, one bit per clock
// - Mode 0 transmit: 8 bits then done flag
// - Mode 0 receive while enabled and flag clear
// - Mode 1 frame: start, 8 data, stop
// - Mode 1 baud from timer, doubled option
// - Mode 1 transmit sets done after stop
// - Async receive starts on falling edge
// - Mode 1 accept: flag clear, address gate
// - Accepted: load data, stop bit, flag
// - Next reception waits new falling edge
// - Modes 2/3 frame: start, 8, ninth, stop
// - Mode 2 baud sys/64 or sys/32
// - Modes 2/3 send ninth bit, done after stop
// - Modes 2/3 accept on ninth bit gate
// - Mode 3 equals mode 2, timer baud
// - Async transmit and receive run independently
// - Timer source selectable for modes 1/3
module fsp_serial_port (
  // Clock, reset, enable
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic       ce,
  // Register port
  input  wire logic [7:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  output logic      [7:0] rdata,
  // Baud sources
  input  wire logic       timer1_ovf,
  input  wire logic       timer3_ovf,
  // Serial pins
  input  wire logic       rxd_in,
  output logic            rxd_out,
  output logic            rxd_oe_n,
  output logic            txd_out
);

  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} fsp_rx_state_t;

  fsp_pkg::fsp_ctrl_t ctrl_reg;
  logic [7:0]    pwr_reg, t2con_reg, given_reg, bcast_reg, rx_buf_reg, rdata_reg;
  logic          rxd_meta, rxd_sync, rxd_prev;
  logic [1:0]    div_reg;
  logic          tick_reg;
  logic          tx_busy, tx_line;
  logic [9:0]    tx_shift;
  logic [3:0]    tx_left, tx_tick;
  fsp_rx_state_t rx_state;
  logic [3:0]    rx_tick, rx_cnt;
  logic [8:0]    rx_shift;
  logic          m0_busy, m0_is_tx, m0_clk;
  logic [2:0]    m0_div;
  logic [3:0]    m0_cnt;
  logic [7:0]    m0_shift;
  logic          txd_reg, rxd_out_reg, rxd_oe_n_reg;

  logic       wr_buf, wr_ctrl, sync_mode, dbl, src_pulse, m0_half, m0_rise, m0_last;
  logic       m0_tx_fin, m0_rx_fin, m0_rx_go, a_tx_fin, rx_mid_stop, rx_accept;
  logic       ninth_rx, tx_set, rx_set;
  logic [1:0] div_last;
  logic [2:0] m0_half_len;
  logic [7:0] rx_data;
  logic [3:0] rx_last;

  assign wr_buf    = wr && addr == fsp_pkg::OFS_BUF;
  assign wr_ctrl   = wr && addr == fsp_pkg::OFS_CTRL;
  assign sync_mode = ctrl_reg.mode == fsp_pkg::MODE_SYNC;
  assign dbl       = pwr_reg[fsp_pkg::BIT_DOUBLE];

  // Register file
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pwr_reg   <= fsp_pkg::PWR_RST;
      t2con_reg <= fsp_pkg::T2CON_RST;
      given_reg <= fsp_pkg::GIVEN_RST;
      bcast_reg <= fsp_pkg::BCAST_RST;
    end else if (ce && wr) begin
      case (addr)
        fsp_pkg::OFS_PWR:   pwr_reg   <= wdata;
        fsp_pkg::OFS_T2CON: t2con_reg <= wdata;
        fsp_pkg::OFS_GIVEN: given_reg <= wdata;
        fsp_pkg::OFS_BCAST: bcast_reg <= wdata;
        default: ;
      endcase
    end
  end

  // Control flags: hardware set wins over a software clear in the same cycle
  assign tx_set = m0_tx_fin || a_tx_fin;
  assign rx_set = m0_rx_fin || rx_accept;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ctrl_reg <= fsp_pkg::CTRL_RST;
    end else if (ce) begin
      if (wr_ctrl) ctrl_reg <= wdata;
      if (tx_set) ctrl_reg.tx_done <= 1'b1;
      if (rx_set) ctrl_reg.rx_done <= 1'b1;
      if (rx_accept) ctrl_reg.rx9 <= ninth_rx;
    end
  end

  // Read port: buffer address returns the receive register
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rdata_reg <= 8'h00;
    end else if (ce) begin
      if (rd) begin
        case (addr)
          fsp_pkg::OFS_BUF:   rdata_reg <= rx_buf_reg;
          fsp_pkg::OFS_CTRL:  rdata_reg <= ctrl_reg;
          fsp_pkg::OFS_PWR:   rdata_reg <= pwr_reg;
          fsp_pkg::OFS_T2CON: rdata_reg <= t2con_reg;
          fsp_pkg::OFS_GIVEN: rdata_reg <= given_reg;
          fsp_pkg::OFS_BCAST: rdata_reg <= bcast_reg;
          default:            rdata_reg <= 8'h00;
        endcase
      end else begin
        rdata_reg <= 8'h00;
      end
    end
  end

  // Receive pin synchroniser and edge history
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rxd_meta <= 1'b1;
      rxd_sync <= 1'b1;
      rxd_prev <= 1'b1;
    end else if (ce) begin
      rxd_meta <= rxd_in;
      rxd_sync <= rxd_meta;
      rxd_prev <= rxd_sync;
    end
  end

  // Sixteen-times oversample tick
  always_comb begin
    if (ctrl_reg.mode == fsp_pkg::MODE_FIX11) begin
      src_pulse = 1'b1;
      div_last  = dbl ? fsp_pkg::FIX_DIV_LAST_DBL : fsp_pkg::FIX_DIV_LAST;
    end else begin
      src_pulse = t2con_reg[fsp_pkg::BIT_SRCSEL] ? timer3_ovf : timer1_ovf;
      div_last  = dbl ? fsp_pkg::TMR_DIV_LAST_DBL : fsp_pkg::TMR_DIV_LAST;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      div_reg  <= 2'h0;
      tick_reg <= 1'b0;
    end else if (ce) begin
      tick_reg <= 1'b0;
      if (src_pulse) begin
        if (div_reg >= div_last) begin
          div_reg  <= 2'h0;
          tick_reg <= 1'b1;
        end else begin
          div_reg <= div_reg + 2'h1;
        end
      end
    end
  end

  // Asynchronous transmitter
  assign a_tx_fin = tx_busy && tick_reg && tx_tick == fsp_pkg::TICK_LAST && tx_left == 4'h0;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      tx_busy  <= 1'b0;
      tx_line  <= 1'b1;
      tx_shift <= 10'h3ff;
      tx_left  <= 4'h0;
      tx_tick  <= 4'h0;
    end else if (ce) begin
      if (wr_buf && !sync_mode) begin
        tx_busy <= 1'b1;
        tx_line <= 1'b0;
        tx_tick <= 4'h0;
        if (ctrl_reg.mode == fsp_pkg::MODE_TMR10) begin
          tx_shift <= {2'b11, wdata};
          tx_left  <= fsp_pkg::TX_LEFT_10;
        end else begin
          tx_shift <= {1'b1, ctrl_reg.tx9, wdata};
          tx_left  <= fsp_pkg::TX_LEFT_11;
        end
      end else if (tx_busy && tick_reg) begin
        tx_tick <= tx_tick + 4'h1;
        if (tx_tick == fsp_pkg::TICK_LAST) begin
          if (tx_left == 4'h0) begin
            tx_busy <= 1'b0;
          end else begin
            tx_line  <= tx_shift[0];
            tx_shift <= {1'b1, tx_shift[9:1]};
            tx_left  <= tx_left - 4'h1;
          end
        end
      end
    end
  end

  // Asynchronous receiver
  assign rx_last     = ctrl_reg.mode == fsp_pkg::MODE_TMR10 ? fsp_pkg::RX_LAST_8
                                                            : fsp_pkg::RX_LAST_9;
  assign rx_data     = ctrl_reg.mode == fsp_pkg::MODE_TMR10 ? rx_shift[8:1] : rx_shift[7:0];
  assign ninth_rx    = ctrl_reg.mode == fsp_pkg::MODE_TMR10 ? rxd_sync : rx_shift[8];
  assign rx_mid_stop = rx_state == RX_STOP && tick_reg && rx_tick == fsp_pkg::TICK_LAST;
  assign rx_accept   = rx_mid_stop && !ctrl_reg.rx_done && (!ctrl_reg.mp_sel ||
                       (ninth_rx && (rx_data == given_reg || rx_data == bcast_reg)));

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rx_state <= RX_IDLE;
      rx_tick  <= 4'h0;
      rx_cnt   <= 4'h0;
      rx_shift <= 9'h000;
    end else if (ce) begin
      if (sync_mode || !ctrl_reg.rx_en) begin
        rx_state <= RX_IDLE;
      end else begin
        case (rx_state)
          RX_IDLE: begin
            if (rxd_prev && !rxd_sync) begin
              rx_state <= RX_START;
              rx_tick  <= 4'h0;
            end
          end
          RX_START: begin
            if (tick_reg) begin
              rx_tick <= rx_tick + 4'h1;
              if (rx_tick == fsp_pkg::TICK_MID) begin
                rx_tick  <= 4'h0;
                rx_cnt   <= 4'h0;
                rx_state <= rxd_sync ? RX_IDLE : RX_DATA;
              end
            end
          end
          RX_DATA: begin
            if (tick_reg) begin
              rx_tick <= rx_tick + 4'h1;
              if (rx_tick == fsp_pkg::TICK_LAST) begin
                rx_shift <= {rxd_sync, rx_shift[8:1]};
                rx_cnt   <= rx_cnt + 4'h1;
                if (rx_cnt == rx_last) rx_state <= RX_STOP;
              end
            end
          end
          RX_STOP: begin
            if (tick_reg) begin
              rx_tick <= rx_tick + 4'h1;
              if (rx_tick == fsp_pkg::TICK_LAST) rx_state <= RX_IDLE;
            end
          end
          default: rx_state <= RX_IDLE;
        endcase
      end
    end
  end

  // Receive buffer, loaded only on an accepted async frame or a finished mode 0 receive
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rx_buf_reg <= 8'h00;
    end else if (ce) begin
      if (rx_accept) rx_buf_reg <= rx_data;
      else if (m0_rx_fin) rx_buf_reg <= {rxd_sync, m0_shift[7:1]};
    end
  end

  // Mode 0 shift engine
  assign m0_half_len = ctrl_reg.mp_sel ? fsp_pkg::M0_HALF_FAST : fsp_pkg::M0_HALF_SLOW;
  assign m0_half     = m0_busy && m0_div == 3'h0;
  assign m0_rise     = m0_half && !m0_clk;
  assign m0_last     = m0_rise && m0_cnt == fsp_pkg::M0_LAST_BIT;
  assign m0_tx_fin   = m0_last && m0_is_tx;
  assign m0_rx_fin   = m0_last && !m0_is_tx;
  assign m0_rx_go    = sync_mode && !m0_busy && ctrl_reg.rx_en && !ctrl_reg.rx_done && !wr_buf;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      m0_busy  <= 1'b0;
      m0_is_tx <= 1'b0;
      m0_clk   <= 1'b1;
      m0_div   <= 3'h0;
      m0_cnt   <= 4'h0;
      m0_shift <= 8'h00;
    end else if (ce) begin
      if (wr_buf && sync_mode) begin
        m0_busy  <= 1'b1;
        m0_is_tx <= 1'b1;
        m0_clk   <= 1'b1;
        m0_div   <= m0_half_len - 3'h1;
        m0_cnt   <= 4'h0;
        m0_shift <= wdata;
      end else if (m0_rx_go) begin
        m0_busy  <= 1'b1;
        m0_is_tx <= 1'b0;
        m0_clk   <= 1'b1;
        m0_div   <= m0_half_len - 3'h1;
        m0_cnt   <= 4'h0;
      end else if (m0_busy) begin
        if (m0_half) begin
          m0_div <= m0_half_len - 3'h1;
          m0_clk <= !m0_clk;
          if (m0_rise) begin
            m0_cnt   <= m0_cnt + 4'h1;
            m0_shift <= {rxd_sync, m0_shift[7:1]};
            if (m0_last) m0_busy <= 1'b0;
          end
        end else begin
          m0_div <= m0_div - 3'h1;
        end
      end
    end
  end

  // Pin drivers
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      txd_reg      <= 1'b1;
      rxd_out_reg  <= 1'b1;
      rxd_oe_n_reg <= 1'b1;
    end else if (ce) begin
      txd_reg      <= sync_mode ? m0_clk : tx_line;
      rxd_out_reg  <= m0_shift[0];
      rxd_oe_n_reg <= !(sync_mode && m0_busy && m0_is_tx);
    end
  end

  assign rdata    = rdata_reg;
  assign txd_out  = txd_reg;
  assign rxd_out  = rxd_out_reg;
  assign rxd_oe_n = rxd_oe_n_reg;

  // Checks
  sequence s_m0_tx_begin;
    ce && wr_buf && sync_mode;
  endsequence

  sequence s_m0_drive;
    ##2 !rxd_oe_n;
  endsequence

  property p_buf_split;
    @(posedge sys_clk) disable iff (rst) ce && wr_buf && !rx_set |=> $stable(rx_buf_reg);
  endproperty
  a_buf_split: assert property (p_buf_split) else $error("buffer write changed receive data");

  property p_tx_start;
    @(posedge sys_clk) disable iff (rst) ce && wr_buf && !sync_mode |=> tx_busy && !tx_line;
  endproperty
  a_tx_start: assert property (p_tx_start) else $error("async transmit did not start");

  property p_m0_drive;
    @(posedge sys_clk) disable iff (rst) s_m0_tx_begin |-> s_m0_drive;
  endproperty
  a_m0_drive: assert property (p_m0_drive) else $error("mode 0 data pin not driven");

  property p_m0_fast;
    @(posedge sys_clk) disable iff (rst) ce && m0_busy && ctrl_reg.mp_sel |-> m0_div == 3'h0;
  endproperty
  a_m0_fast: assert property (p_m0_fast) else $error("mode 0 fast clock wrong");

  property p_m0_done;
    @(posedge sys_clk) disable iff (rst) ce && m0_tx_fin |=> ctrl_reg.tx_done && !m0_busy;
  endproperty
  a_m0_done: assert property (p_m0_done) else $error("mode 0 done flag missing");

  property p_flag_hold;
    @(posedge sys_clk) disable iff (rst) ctrl_reg.rx_done && !(ce && wr_ctrl) |=> ctrl_reg.rx_done;
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("receive flag cleared by hardware");

  property p_full_block;
    @(posedge sys_clk) disable iff (rst) ce && rx_mid_stop && ctrl_reg.rx_done
      |=> $stable(rx_buf_reg);
  endproperty
  a_full_block: assert property (p_full_block) else $error("frame loaded over full buffer");

  property p_start_check;
    @(posedge sys_clk) disable iff (rst) ce && rx_state == RX_START && tick_reg
      && rx_tick == fsp_pkg::TICK_MID && rxd_sync && ctrl_reg.rx_en |=> rx_state == RX_IDLE;
  endproperty
  a_start_check: assert property (p_start_check) else $error("false start not rejected");

  property p_accept_load;
    @(posedge sys_clk) disable iff (rst) ce && rx_accept
      |=> ctrl_reg.rx_done && rx_buf_reg == $past(rx_data);
  endproperty
  a_accept_load: assert property (p_accept_load) else $error("accepted frame not loaded");

  property p_set_wins;
    @(posedge sys_clk) disable iff (rst) ce && a_tx_fin |=> ctrl_reg.tx_done;
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("transmit done lost");

endmodule : fsp_serial_port

`default_nettype wire

/* File: fsp_peer.sv */
// Far-side serial device: async sender and receiver, mode 0 slave shifter.
// Assumes the bench calls its tasks; everything is timed on the system clock.
`timescale 1ns/1ps
`default_nettype none
module fsp_peer (
  // Clock
  input  wire logic sys_clk,
  // Device pins
  input  wire logic txd_out,
  input  wire logic rxd_out,
  input  wire logic rxd_oe_n,
  output logic      rxd_in
);
  logic       tx_line = 1'b1;
  logic       m0_en   = 1'b0;
  logic       prev    = 1'b1;
  logic [7:0] m0_src  = 8'h00;
  logic [7:0] m0_cap  = 8'h00;

  // Pulled-up data line: device when it drives, else slave bit or async line
  assign rxd_in = !rxd_oe_n ? rxd_out : (m0_en ? m0_src[0] : tx_line);

  // Slave takes data while the clock is low and moves on after each rise
  always @(posedge sys_clk) begin
    prev <= txd_out;
    if (prev && !txd_out && !rxd_oe_n) m0_cap <= {rxd_out, m0_cap[7:1]};
    if (!prev && txd_out && m0_en && rxd_oe_n) m0_src <= {~m0_src[0], m0_src[7:1]};
  end

  task automatic slave(input logic en, input logic [7:0] d);
    @(posedge sys_clk);
    m0_en  <= en;
    m0_src <= d;
  endtask : slave

  task automatic send(input logic [10:0] f, input int n, input int per);
    for (int i = 0; i < n; i++) begin
      @(posedge sys_clk);
      tx_line <= f[i];
      repeat (per - 1) @(posedge sys_clk);
    end
  endtask : send

  task automatic recv(input int n, input int per, output logic [10:0] f, output bit lost);
    int w;
    f    = 11'h000;
    lost = 1'b1;
    for (w = 0; w < 400; w++) begin
      @(posedge sys_clk);
      if (!txd_out) break;
    end
    if (w < 400) begin
      lost = 1'b0;
      repeat (per / 2) @(posedge sys_clk);
      for (int i = 0; i < n; i++) begin
        f[i] = txd_out;
        if (i < n - 1) repeat (per) @(posedge sys_clk);
      end
    end
  endtask : recv
endmodule : fsp_peer
`default_nettype wire

/* File: fsp_serial_port_test.sv */
// Self-checking bench for the four-mode serial port.
// Assumes fsp_pkg, the design and the far-side model fsp_peer.
`timescale 1ns/1ps
`default_nettype none
module fsp_serial_port_test;
  logic       sys_clk    = 1'b0;
  logic       rst        = 1'b1;
  logic [7:0] addr       = 8'h00;
  logic [7:0] wdata      = 8'h00;
  logic       wr         = 1'b0;
  logic       rd         = 1'b0;
  logic       timer1_ovf = 1'b0;
  logic       timer3_ovf = 1'b0;
  logic [1:0] tcnt       = 2'h0;
  logic       ce         = 1'b1;
  logic [7:0] rdata;
  wire logic  rxd_in, rxd_out, rxd_oe_n, txd_out;
  int         n_errors   = 0;
  int         n_compared = 0;

  // Multiprocessor frames: data, ninth bit, and whether the gate should accept
  localparam logic [7:0] MP_D [4] = '{8'h5a, 8'h5a, 8'h11, 8'hff};
  localparam logic [3:0] MP_NINTH = 4'b1110;
  localparam logic [3:0] MP_OK    = 4'b1010;

  fsp_serial_port dut (.sys_clk(sys_clk), .rst(rst), .ce(ce), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .timer1_ovf(timer1_ovf), .timer3_ovf(timer3_ovf),
    .rxd_in(rxd_in), .rxd_out(rxd_out), .rxd_oe_n(rxd_oe_n), .txd_out(txd_out));
  fsp_peer peer (.sys_clk(sys_clk), .txd_out(txd_out), .rxd_out(rxd_out),
    .rxd_oe_n(rxd_oe_n), .rxd_in(rxd_in));

  initial begin
    forever #5 sys_clk = ~sys_clk;
  end

  // Timer 1 overflows every 2 clocks, timer 3 every 4
  always @(posedge sys_clk) begin
    tcnt       <= tcnt + 2'h1;
    timer1_ovf <= tcnt[0];
    timer3_ovf <= (tcnt == 2'h3);
  end

  task automatic end_sim;
    if (n_errors == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : end_sim

  task automatic chk(input string nm, input logic [10:0] e, input logic [10:0] g);
    n_compared++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge sys_clk);
    wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge sys_clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask : rd_reg

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] v;
    rd_reg(a, v);
    chk($sformatf("reg %h", a), {3'h0, e}, {3'h0, v});
  endtask : rd_chk

  task automatic wait_flag(input int b);
    logic [7:0] v;
    int         k;
    for (k = 0; k < 60; k++) begin
      rd_reg(fsp_pkg::OFS_CTRL, v);
      if (v[b] === 1'b1) break;
      repeat (10) @(posedge sys_clk);
    end
    if (k == 60) begin
      n_errors++;
      end_sim();
    end
  endtask : wait_flag

  task automatic rise_gap(output int p);
    int   t0;
    logic pv;
    t0 = -1;
    p  = 0;
    pv = txd_out;
    for (int c = 0; c < 300 && p == 0; c++) begin
      @(posedge sys_clk);
      #1;
      if (txd_out && !pv) begin
        if (t0 < 0) t0 = c;
        else p = c - t0;
      end
      pv = txd_out;
    end
  endtask : rise_gap

  task automatic tx_case(input logic [7:0] c, input logic [7:0] pw, input logic [7:0] t2,
                         input logic [7:0] d, input int n, input int per);
    logic [10:0] f;
    logic [10:0] e;
    bit          lost;
    e = (n == 10) ? {2'b01, d, 1'b0} : {1'b1, c[3], d, 1'b0};
    wr_reg(fsp_pkg::OFS_PWR, pw);
    wr_reg(fsp_pkg::OFS_T2CON, t2);
    wr_reg(fsp_pkg::OFS_CTRL, c);
    fork
      peer.recv(n, per, f, lost);
      wr_reg(fsp_pkg::OFS_BUF, d);
    join
    if (lost) begin
      n_errors++;
      end_sim();
    end
    chk("frame", e, f);
    rd_chk(fsp_pkg::OFS_CTRL, c);
    repeat (per) @(posedge sys_clk);
    rd_chk(fsp_pkg::OFS_CTRL, c | 8'h02);
  endtask : tx_case

  initial begin
    repeat (100000) @(posedge sys_clk);
    n_errors++;
    end_sim();
  end

  initial begin
    logic [10:0] f;
    bit          lost;
    int          p;
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    #1;
    chk("idle pins", 11'h003, {9'h000, txd_out, rxd_oe_n});
    wr_reg(8'h20, 8'hff);
    rd_chk(8'h20, 8'h00);
    rd_chk(fsp_pkg::OFS_CTRL, 8'h00);
    rd_chk(fsp_pkg::OFS_PWR, 8'h00);
    rd_chk(fsp_pkg::OFS_T2CON, 8'h00);
    rd_chk(fsp_pkg::OFS_GIVEN, 8'h00);
    rd_chk(fsp_pkg::OFS_BCAST, 8'hff);
    // A write with the clock enable low must be ignored
    @(posedge sys_clk);
    ce <= 1'b0;
    wr_reg(fsp_pkg::OFS_GIVEN, 8'h33);
    ce <= 1'b1;
    rd_chk(fsp_pkg::OFS_GIVEN, 8'h00);
    tx_case(8'h88, 8'h00, 8'h00, 8'ha5, 11, 64);
    tx_case(8'h80, 8'h80, 8'h20, 8'h3c, 11, 32);
    tx_case(8'h40, 8'h00, 8'h00, 8'h5a, 10, 64);
    tx_case(8'h40, 8'h80, 8'h00, 8'h96, 10, 32);
    tx_case(8'hc0, 8'h00, 8'h20, 8'h69, 11, 128);
    tx_case(8'hc8, 8'h80, 8'h20, 8'hf0, 11, 64);
    wr_reg(fsp_pkg::OFS_PWR, 8'h00);
    wr_reg(fsp_pkg::OFS_T2CON, 8'h00);
    wr_reg(fsp_pkg::OFS_CTRL, 8'h50);
    fork
      peer.send({2'b11, 8'h3c, 1'b0}, 10, 64);
      peer.recv(10, 64, f, lost);
      wr_reg(fsp_pkg::OFS_BUF, 8'hc5);
    join
    repeat (100) @(posedge sys_clk);
    chk("frame", {2'b01, 8'hc5, 1'b0}, f);
    rd_chk(fsp_pkg::OFS_CTRL, 8'h57);
    rd_chk(fsp_pkg::OFS_BUF, 8'h3c);
    peer.send({2'b11, 8'h81, 1'b0}, 10, 64);
    repeat (100) @(posedge sys_clk);
    rd_chk(fsp_pkg::OFS_BUF, 8'h3c);
    rd_chk(fsp_pkg::OFS_CTRL, 8'h57);
    wr_reg(fsp_pkg::OFS_CTRL, 8'h50);
    peer.send(11'h002, 2, 3);
    repeat (800) @(posedge sys_clk);
    rd_chk(fsp_pkg::OFS_CTRL, 8'h50);
    peer.send({2'b11, 8'h77, 1'b0}, 10, 64);
    repeat (100) @(posedge sys_clk);
    rd_chk(fsp_pkg::OFS_CTRL, 8'h55);
    rd_chk(fsp_pkg::OFS_BUF, 8'h77);
    wr_reg(fsp_pkg::OFS_GIVEN, 8'h5a);
    for (int i = 0; i < 4; i++) begin
      wr_reg(fsp_pkg::OFS_CTRL, 8'hb0);
      peer.send({1'b1, MP_NINTH[i], MP_D[i], 1'b0}, 11, 64);
      repeat (100) @(posedge sys_clk);
      rd_chk(fsp_pkg::OFS_CTRL, MP_OK[i] ? 8'hb5 : 8'hb0);
      if (MP_OK[i]) rd_chk(fsp_pkg::OFS_BUF, MP_D[i]);
    end
    for (int i = 0; i < 2; i++) begin
      wr_reg(fsp_pkg::OFS_CTRL, {2'h0, i[0], 5'h00});
      fork
        rise_gap(p);
        wr_reg(fsp_pkg::OFS_BUF, 8'h96 ^ i[7:0]);
      join
      wait_flag(1);
      chk("shift period", i ? 11'h002 : 11'h00c, p[10:0]);
      chk("shift data", {3'h0, 8'h96 ^ i[7:0]}, {3'h0, peer.m0_cap});
    end
    peer.slave(1'b1, 8'hc3);
    wr_reg(fsp_pkg::OFS_CTRL, 8'h10);
    wait_flag(0);
    rd_chk(fsp_pkg::OFS_BUF, 8'hc3);
    peer.slave(1'b1, 8'h5e);
    wr_reg(fsp_pkg::OFS_CTRL, 8'h10);
    wait_flag(0);
    rd_chk(fsp_pkg::OFS_BUF, 8'h5e);
    peer.slave(1'b0, 8'h00);
    end_sim();
  end
endmodule : fsp_serial_port_test
`default_nettype wire
